// >>> hdl/apdg_drive.v
/*
  Single-axis pulse drive generator with its Wishbone register file.
  Assumes a classic Wishbone master on core_clk, stop inputs already
  synchronous to core_clk, and a driver that takes one-cycle step pulses.
*/
`timescale 1ns/100ps
`include "apdg_consts.vh"

module apdg_drive #(
  parameter SPD_W = 16,
  parameter CNT_W = 32,
  parameter PH_W = 24
)(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Stop inputs
  input wire [3:0] external_stop_inputs,
  // Drive outputs
  output reg drive_pulse,
  output reg drive_dir,
  output wire drive_busy
);

localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_ACCEL = 4'h2;
localparam [3:0] ST_CONST = 4'h4;
localparam [3:0] ST_DECEL = 4'h8;

////////////////////////////////////////////////////////////////////////////
// Byte-lane merge, used by every writable register
function [31:0] lane_merge;
  input [31:0] old_val;
  input [31:0] new_val;
  input [3:0] sel;
  integer i;
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      lane_merge[i*8 +: 8] = sel[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
    end
  end
endfunction

reg [3:0] state;
reg [2:0] drive_mode_register;
reg [11:0] stop_input_config_register;
reg [SPD_W-1:0] initial_speed_param;
reg [SPD_W-1:0] drive_speed;
reg [SPD_W-1:0] accel_rate;
reg [CNT_W-1:0] pulse_target;
reg [CNT_W-1:0] decel_point;
reg [CNT_W-1:0] dpoint_data;
reg [15:0] accel_offset;
reg [CNT_W-1:0] out_count;
reg [CNT_W-1:0] accel_pulses;
reg [SPD_W-1:0] cur_speed;
reg [SPD_W-1:0] rate_acc;
reg [PH_W-1:0] phase_acc;
reg fixed_drive;
reg stop_pending;
reg [1:0] last_stop;

wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire bus_wr = bus_req & wb_we_i;
wire cmd_wr = bus_wr & (wb_adr_i == `APDG_ADR_CMD) & wb_sel_i[0];
wire [7:0] cmd_code = wb_dat_i[7:0];
wire running = ~state[0];
wire scurve = drive_mode_register[`APDG_MODE_SCURVE];

////////////////////////////////////////////////////////////////////////////
// Bus slave: one wait state, ack for one cycle, unmapped reads zero
always @(posedge core_clk)
begin
  if (rst)
  begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0000_0000;
  end
  else
  begin
    wb_ack_o <= bus_req;
    wb_dat_o <= 32'h0000_0000;
    if (bus_req & ~wb_we_i)
    begin
      case (wb_adr_i)
        `APDG_ADR_MODE: wb_dat_o <= {29'h0, drive_mode_register};
        `APDG_ADR_STOPCFG: wb_dat_o <= {20'h0, stop_input_config_register};
        `APDG_ADR_INIT_SPD: wb_dat_o <= {{(32-SPD_W){1'b0}},
          initial_speed_param};
        `APDG_ADR_DRV_SPD: wb_dat_o <= {{(32-SPD_W){1'b0}}, drive_speed};
        `APDG_ADR_ACCEL: wb_dat_o <= {{(32-SPD_W){1'b0}}, accel_rate};
        `APDG_ADR_PCOUNT: wb_dat_o <= pulse_target;
        `APDG_ADR_DPOINT: wb_dat_o <= decel_point;
        `APDG_ADR_OFFSET: wb_dat_o <= {16'h0, accel_offset};
        `APDG_ADR_STATUS: wb_dat_o <= {22'h0, last_stop, state,
          stop_pending, fixed_drive, drive_dir, running};
        `APDG_ADR_OUTCNT: wb_dat_o <= out_count;
        `APDG_ADR_CURSPD: wb_dat_o <= {{(32-SPD_W){1'b0}}, cur_speed};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Parameter registers
// Byte-lane merged write words, cut to width below
wire [31:0] mrg_mode = lane_merge({29'h0, drive_mode_register},
  wb_dat_i, wb_sel_i);
wire [31:0] mrg_cfg = lane_merge({20'h0, stop_input_config_register},
  wb_dat_i, wb_sel_i);
wire [31:0] mrg_init = lane_merge({{(32-SPD_W){1'b0}},
  initial_speed_param}, wb_dat_i, wb_sel_i);
wire [31:0] mrg_drv = lane_merge({{(32-SPD_W){1'b0}}, drive_speed},
  wb_dat_i, wb_sel_i);
wire [31:0] mrg_accel = lane_merge({{(32-SPD_W){1'b0}}, accel_rate},
  wb_dat_i, wb_sel_i);
wire [31:0] mrg_offset = lane_merge({16'h0, accel_offset}, wb_dat_i,
  wb_sel_i);
always @(posedge core_clk)
begin
  if (rst)
  begin
    drive_mode_register <= 3'h0;
    stop_input_config_register <= 12'h000;
    initial_speed_param <= `APDG_RST_INIT_SPD;
    drive_speed <= `APDG_RST_DRV_SPD;
    accel_rate <= {SPD_W{1'b0}};
    pulse_target <= {CNT_W{1'b0}};
    dpoint_data <= {CNT_W{1'b0}};
    decel_point <= {CNT_W{1'b0}};
    accel_offset <= `APDG_RST_OFFSET;
  end
  else
  begin
    if (bus_wr)
    begin
      case (wb_adr_i)
        `APDG_ADR_MODE: drive_mode_register <= mrg_mode[2:0];
        `APDG_ADR_STOPCFG: stop_input_config_register <= mrg_cfg[11:0];
        `APDG_ADR_INIT_SPD: initial_speed_param <= mrg_init[SPD_W-1:0];
        `APDG_ADR_DRV_SPD:
          if (~(running & fixed_drive & scurve))
            drive_speed <= mrg_drv[SPD_W-1:0];
        `APDG_ADR_ACCEL: accel_rate <= mrg_accel[SPD_W-1:0];
        `APDG_ADR_PCOUNT: pulse_target <= lane_merge(pulse_target,
          wb_dat_i, wb_sel_i);
        `APDG_ADR_DPOINT: dpoint_data <= lane_merge(dpoint_data,
          wb_dat_i, wb_sel_i);
        `APDG_ADR_OFFSET: accel_offset <= mrg_offset[15:0];
        default: ;
      endcase
    end
    if (cmd_wr & (cmd_code == `APDG_CMD_DPOINT))
      decel_point <= dpoint_data;
  end
end

////////////////////////////////////////////////////////////////////////////
// Stop input decode
wire [3:0] stop_en = stop_input_config_register[`APDG_CFG_EN_LSB +: 4];
wire [3:0] stop_lvl = stop_input_config_register[`APDG_CFG_LVL_LSB +: 4];
wire [3:0] stop_sud = stop_input_config_register[`APDG_CFG_SUD_LSB +: 4];
wire [3:0] stop_act;
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1)
  begin : g_stop
    assign stop_act[gi] = stop_en[gi] &
      (external_stop_inputs[gi] == stop_lvl[gi]);
  end
endgenerate

// sudden when flat, or input set sudden
wire ext_sudden = |(stop_act & stop_sud) | (state[2] & ~fixed_drive &
  (|stop_act) & ~(drive_speed > initial_speed_param));
// any other active input ramps down
wire ext_decel = |(stop_act & ~stop_sud);

wire cmd_start = cmd_wr & ~running & ((cmd_code == `APDG_CMD_FIX_P) |
  (cmd_code == `APDG_CMD_FIX_M) | (cmd_code == `APDG_CMD_CONT_P) |
  (cmd_code == `APDG_CMD_CONT_M));
wire cmd_dstop = cmd_wr & (cmd_code == `APDG_CMD_DSTOP);
wire cmd_sstop = cmd_wr & (cmd_code == `APDG_CMD_SSTOP);

////////////////////////////////////////////////////////////////////////////
// Speed arithmetic
wire [PH_W:0] phase_sum = {1'b0, phase_acc} +
  {{(PH_W+1-SPD_W){1'b0}}, cur_speed};
wire [SPD_W:0] rate_sum = {1'b0, rate_acc} + {1'b0, accel_rate};
wire step = rate_sum[SPD_W];
wire emit = running & phase_sum[PH_W];
// drive speed not above initial speed runs flat
wire ramped = drive_speed > initial_speed_param;
wire [SPD_W-1:0] top_speed = ramped ? drive_speed : initial_speed_param;
wire [CNT_W-1:0] remaining = pulse_target - out_count;
wire [CNT_W+1:0] acc_thr = {2'b00, accel_pulses} +
  {{(CNT_W-14){accel_offset[15]}}, accel_offset};
// auto point, moved earlier by offset
wire auto_hit = $signed({2'b00, remaining}) <= $signed(acc_thr);
wire dec_hit = drive_mode_register[`APDG_MODE_MANUAL] ?
  (remaining <= decel_point) : auto_hit;
wire count_done = fixed_drive & (out_count == pulse_target);
// count set below pulses already out
wire count_short = fixed_drive & (pulse_target < out_count);
wire early_end = fixed_drive & ~accel_offset[15] ? 1'b0 :
  fixed_drive & state[3] & (cur_speed <= initial_speed_param) &
  ($signed(acc_thr) < $signed({(CNT_W+2){1'b0}}));

////////////////////////////////////////////////////////////////////////////
// Drive sequencer
reg [3:0] next_state;
always @*
begin
  next_state = state;
  case (state)
    ST_IDLE:
      if (cmd_start)
        next_state = ramped ? ST_ACCEL : ST_CONST;
    ST_ACCEL, ST_CONST:
      if (cmd_sstop | ext_sudden | count_done | count_short)
        next_state = ST_IDLE;
      else if (cmd_dstop | ext_decel | stop_pending |
        (fixed_drive & ramped & dec_hit))
        next_state = ramped ? ST_DECEL : ST_IDLE;
      else if (cur_speed < top_speed)
        next_state = ST_ACCEL;
      else
        next_state = ST_CONST;
    ST_DECEL:
      if (cmd_sstop | ext_sudden | count_done | count_short | early_end |
        (~fixed_drive & (cur_speed <= initial_speed_param)))
        next_state = ST_IDLE;
    default: next_state = ST_IDLE;
  endcase
end

assign drive_busy = running;

always @(posedge core_clk)
begin
  if (rst)
  begin
    state <= ST_IDLE;
    cur_speed <= {SPD_W{1'b0}};
    rate_acc <= {SPD_W{1'b0}};
    phase_acc <= {PH_W{1'b0}};
    out_count <= {CNT_W{1'b0}};
    accel_pulses <= {CNT_W{1'b0}};
    fixed_drive <= 1'b0;
    stop_pending <= 1'b0;
    last_stop <= 2'b00;
    drive_pulse <= 1'b0;
    drive_dir <= 1'b0;
  end
  else
  begin
    state <= next_state;
    // no pulse once count met or cut short
    drive_pulse <= emit & ~count_done & ~count_short & ~state[0] &
      ~next_state[0];
    if (state[0])
    begin
      phase_acc <= {PH_W{1'b0}};
      rate_acc <= {SPD_W{1'b0}};
      stop_pending <= 1'b0;
      if (cmd_start)
      begin
        // fixed or continuous, plus or minus
        fixed_drive <= ~cmd_code[1];
        drive_dir <= cmd_code[0];
        cur_speed <= initial_speed_param;
        out_count <= {CNT_W{1'b0}};
        accel_pulses <= {CNT_W{1'b0}};
        last_stop <= 2'b00;
      end
    end
    else
    begin
      phase_acc <= phase_sum[PH_W-1:0];
      rate_acc <= rate_sum[SPD_W-1:0];
      if (emit & ~count_done & ~count_short)
        out_count <= out_count + {{(CNT_W-1){1'b0}}, 1'b1};
      if (state[1] & emit)
        accel_pulses <= accel_pulses + {{(CNT_W-1){1'b0}}, 1'b1};
      // decel stop seen while ramping up is kept
      if (cmd_dstop | ext_decel)
        stop_pending <= 1'b1;
      if (step & state[1] & (cur_speed < top_speed))
        cur_speed <= cur_speed + {{(SPD_W-1){1'b0}}, 1'b1};
      else if (step & state[2] & (cur_speed > top_speed))
        cur_speed <= cur_speed - {{(SPD_W-1){1'b0}}, 1'b1};
      // linear ramp down at accel slope
      else if (step & state[3] & (cur_speed > initial_speed_param))
        cur_speed <= cur_speed - {{(SPD_W-1){1'b0}}, 1'b1};
      if (cmd_sstop | ext_sudden)
        last_stop <= 2'b10;
      else if (cmd_dstop | ext_decel)
        last_stop <= 2'b01;
      else if (count_done | count_short)
        last_stop <= 2'b11;
    end
  end
end

endmodule

// >>> hdl/apdg_consts.vh
/*
  Register map, field positions, reset values and command codes of the
  axis pulse drive generator. Assumes a 32-bit classic Wishbone slave.
*/
// What this block does
// - Fixed-count drive emits exactly the programmed pulse count, then ends.
// - Auto decel starts when remaining pulses fall to accel pulses plus offset.
// - New pulse count accepted mid-drive; below pulses output halts at once.
// - S-curve count change may end with unfinished deceleration.
// - Drive speed change accepted in linear or constant fixed-count drive with S-curve mode off.
// - Drive speed write ignored during running S-curve fixed-count drive.
// - Offset moves decel start earlier; negative offset may stop early.
// - Acceleration counter offset resets to 8.
// - Continuous drive runs until stop command or enabled stop input.
// - Continuous drive applies speed changes at any time without stopping.
// - Two stop commands: decelerating stop and sudden stop.
// - Four stop inputs, each with enable, active level and stop mode.
// - Ramped continuous drive decelerates to stop on any enabled input not set sudden.
// - Constant-speed continuous drive stops at once on any enabled stop input.
// - Drive speed at or below initial speed gives constant-speed drive.
// - Drives start by fixed or continuous command, plus or minus each.
// - Symmetric deceleration ramps down at the accel slope to initial speed.
`ifndef APDG_CONSTS_VH
`define APDG_CONSTS_VH

`define APDG_ADR_CMD 8'h00
`define APDG_ADR_MODE 8'h04
`define APDG_ADR_STOPCFG 8'h08
`define APDG_ADR_INIT_SPD 8'h0C
`define APDG_ADR_DRV_SPD 8'h10
`define APDG_ADR_ACCEL 8'h14
`define APDG_ADR_PCOUNT 8'h18
`define APDG_ADR_DPOINT 8'h1C
`define APDG_ADR_OFFSET 8'h20
`define APDG_ADR_STATUS 8'h24
`define APDG_ADR_OUTCNT 8'h28
`define APDG_ADR_CURSPD 8'h2C

`define APDG_MODE_MANUAL 0
`define APDG_MODE_SEPDEC 1
`define APDG_MODE_SCURVE 2

`define APDG_CFG_EN_LSB 0
`define APDG_CFG_LVL_LSB 4
`define APDG_CFG_SUD_LSB 8

`define APDG_CMD_DPOINT 8'h07
`define APDG_CMD_FIX_P 8'h20
`define APDG_CMD_FIX_M 8'h21
`define APDG_CMD_CONT_P 8'h22
`define APDG_CMD_CONT_M 8'h23
`define APDG_CMD_DSTOP 8'h26
`define APDG_CMD_SSTOP 8'h27

`define APDG_RST_OFFSET 16'h0008
`define APDG_RST_INIT_SPD 16'h0001
`define APDG_RST_DRV_SPD 16'h0001

`endif

// >>> dv/apdg_drive_checker.sv
/*
  Port checks for the pulse drive generator.
  Assumes the offsets and command codes of apdg_consts.vh.
*/
`timescale 1ns/100ps
`include "apdg_consts.vh"

module apdg_drive_checker (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Stops and drive
  input wire [3:0] external_stop_inputs,
  input wire drive_pulse,
  input wire drive_dir,
  input wire drive_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i == `APDG_ADR_CMD && wb_sel_i[0];
  ////////////////////////////////////////////////////////////////////
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) &&
    $past(wb_stb_i)) else $error("ack without request");
  chk_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_start_dir: assert property (cmd_wr && !drive_busy &&
    wb_dat_i[7:2] == 6'h08 |=> drive_busy &&
    drive_dir == $past(wb_dat_i[0])) else $error("start not taken");
  chk_sudden_stop: assert property (cmd_wr && drive_busy &&
    wb_dat_i[7:0] == `APDG_CMD_SSTOP |-> ##[1:3] !drive_busy)
    else $error("sudden stop late");
  chk_idle_quiet: assert property (!drive_busy &&
    !$past(drive_busy) |-> !drive_pulse) else $error("pulse when idle");
  chk_pulse_width: assert property (drive_pulse |=> !drive_pulse)
    else $error("step pulse too long");
  chk_dir_hold: assert property (drive_busy && $past(drive_busy)
    |-> $stable(drive_dir)) else $error("direction moved in drive");
endmodule

// >>> dv/apdg_motor_model.sv
/*
  Step driver model: counts steps by direction, gives a home sensor.
  Assumes one-cycle step pulses synchronous to core_clk.
*/
`timescale 1ns/100ps

module apdg_motor_model (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Steps
  input wire drive_pulse,
  input wire drive_dir,
  // Sensor and position
  input wire [31:0] home_pos,
  output reg signed [31:0] step_pos,
  output reg [31:0] step_cnt,
  output wire home_sense
);
  assign home_sense = step_pos == home_pos;
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      step_pos <= 32'sh0;
      step_cnt <= 32'h0;
    end
    else if (drive_pulse)
    begin
      step_cnt <= step_cnt + 32'h1;
      step_pos <= drive_dir ? step_pos - 32'sh1 : step_pos + 32'sh1;
    end
  end
endmodule

// >>> dv/test_apdg_drive.sv
/*
  Self-checking bench for the pulse drive generator.
  Assumes apdg_consts.vh on the include path and the step model.
*/
`timescale 1ns/100ps
`include "apdg_consts.vh"

module test_apdg_drive;
  logic core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, stop_bits;
  logic [31:0] wb_dat_i, wb_dat_o, home_pos, step_cnt, rd;
  logic signed [31:0] step_pos;
  logic drive_pulse, drive_dir, drive_busy, home_sense;
  wire [3:0] stop_in = stop_bits | {2'b00, home_sense, 1'b0};
  int mismatches, tests_run;

  apdg_drive uut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_stop_inputs(stop_in),
    .drive_pulse(drive_pulse), .drive_dir(drive_dir),
    .drive_busy(drive_busy));
  apdg_motor_model motor (.core_clk(core_clk), .rst(rst),
    .drive_pulse(drive_pulse), .drive_dir(drive_dir), .home_pos(home_pos),
    .step_pos(step_pos), .step_cnt(step_cnt), .home_sense(home_sense));
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] adr,
    input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    chk({31'h0, wb_ack_o}, 32'h1);
  endtask
  task wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask
  task rdc(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  // Bounded wait for the drive to end
  task automatic idle(input int lim);
    int n;
    n = 0;
    while (drive_busy !== 1'b0 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, drive_busy}, 32'h0);
  endtask
  task automatic steps(input int k);
    int n;
    logic [31:0] goal;
    goal = step_cnt + 32'(k);
    n = 0;
    while (step_cnt < goal && n < 30000)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Generous bound: whole sequence needs about 19000 cycles
  initial
  begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    stop_bits = 4'h0;
    home_pos = 32'h7FFF_FFFF;
    rst = 1'b1;
    mismatches = 0;
    tests_run = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rdc(`APDG_ADR_OFFSET, 32'h8);
    rdc(`APDG_ADR_MODE, 32'h0);
    rdc(8'h3C, 32'h0);
    $display("reset test done");
    wr(`APDG_ADR_INIT_SPD, 32'h8000);
    wr(`APDG_ADR_DRV_SPD, 32'h4000);
    wr(`APDG_ADR_PCOUNT, 32'h5);
    wr(`APDG_ADR_CMD, 32'h20);
    rdc(`APDG_ADR_CURSPD, 32'h8000);
    idle(4000);
    chk(step_pos, 32'h5);
    rdc(`APDG_ADR_OUTCNT, 32'h5);
    $display("fixed drive test done");
    wr(`APDG_ADR_PCOUNT, 32'h3);
    wr(`APDG_ADR_CMD, 32'h21);
    steps(1);
    wr(`APDG_ADR_PCOUNT, 32'h6);
    idle(6000);
    chk(step_pos, 32'hFFFF_FFFF);
    wr(`APDG_ADR_PCOUNT, 32'h28);
    wr(`APDG_ADR_CMD, 32'h21);
    steps(3);
    wr(`APDG_ADR_PCOUNT, 32'h1);
    idle(20);
    chk(step_pos, 32'hFFFF_FFFC);
    $display("count change test done");
    wr(`APDG_ADR_ACCEL, 32'hFFFF);
    wr(`APDG_ADR_CMD, 32'h22);
    steps(1);
    wr(`APDG_ADR_DRV_SPD, 32'h8100);
    steps(3);
    rdc(`APDG_ADR_CURSPD, 32'h8100);
    chk({31'h0, drive_busy}, 32'h1);
    wr(`APDG_ADR_CMD, 32'h26);
    idle(2000);
    rdc(`APDG_ADR_STATUS, 32'h110);
    wr(`APDG_ADR_CMD, 32'h22);
    wr(`APDG_ADR_CMD, 32'h27);
    idle(5);
    rdc(`APDG_ADR_STATUS, 32'h210);
    $display("continuous test done");
    wr(`APDG_ADR_STOPCFG, 32'h011);
    stop_bits <= 4'h4;
    wr(`APDG_ADR_CMD, 32'h23);
    steps(1);
    chk({31'h0, drive_busy}, 32'h1);
    stop_bits <= 4'h5;
    idle(3000);
    rdc(`APDG_ADR_STATUS, 32'h112);
    stop_bits <= 4'h0;
    wr(`APDG_ADR_DRV_SPD, 32'h4000);
    wr(`APDG_ADR_STOPCFG, 32'h022);
    home_pos <= step_pos + 32'h3;
    wr(`APDG_ADR_CMD, 32'h22);
    idle(3000);
    chk(step_pos, home_pos);
    rdc(`APDG_ADR_STATUS, 32'h210);
    home_pos <= 32'h7FFF_FFFF;
    $display("stop input test done");
    wr(`APDG_ADR_MODE, 32'h1);
    wr(`APDG_ADR_DPOINT, 32'h2);
    wr(`APDG_ADR_CMD, 32'h07);
    rdc(`APDG_ADR_DPOINT, 32'h2);
    wr(`APDG_ADR_MODE, 32'h4);
    wr(`APDG_ADR_PCOUNT, 32'h4);
    wr(`APDG_ADR_CMD, 32'h20);
    wr(`APDG_ADR_DRV_SPD, 32'h2000);
    rdc(`APDG_ADR_DRV_SPD, 32'h4000);
    idle(3000);
    wr(`APDG_ADR_MODE, 32'h0);
    wr(`APDG_ADR_CMD, 32'h20);
    wr(`APDG_ADR_DRV_SPD, 32'h2000);
    rdc(`APDG_ADR_DRV_SPD, 32'h2000);
    idle(3000);
    $display("speed change test done");
    wr(`APDG_ADR_DRV_SPD, 32'h8100);
    wr(`APDG_ADR_PCOUNT, 32'h6);
    wr(`APDG_ADR_CMD, 32'h20);
    idle(5000);
    rdc(`APDG_ADR_OUTCNT, 32'h6);
    $display("auto decel test done");
    complete_run;
  end
endmodule

bind apdg_drive apdg_drive_checker chk_i (.core_clk(core_clk),
  .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .external_stop_inputs(external_stop_inputs),
  .drive_pulse(drive_pulse), .drive_dir(drive_dir),
  .drive_busy(drive_busy));
